// [mss_regs.svh]
// Constants for the multiplexed scan sequencer
// How it works
// - Repeat list unless single bit stops
// - Each new entry reloads the starting channel
// - Channel seven advances back to zero
// - All-zero config word clears the channel and repeat count
// - Entry count holds channels minus one
`ifndef MSS_REGS_SVH
`define MSS_REGS_SVH

// ----------------------------------------------------------------
// Word widths and list depth
// ----------------------------------------------------------------
`define MSS_CFG_W          32
`define MSS_HARDSCAN_CONTROL_REGISTER_W         8
`define MSS_ENTRY_W        16
`define MSS_FIFO_DEPTH     16

// ----------------------------------------------------------------
// Configuration word fields
// ----------------------------------------------------------------
`define MSS_CFG_REPEAT_HI  30
`define MSS_CFG_REPEAT_LO  24
`define MSS_CFG_START_HI   22
`define MSS_CFG_START_LO   20
`define MSS_CFG_HOST_HI    13
`define MSS_CFG_HOST_LO    12
`define MSS_CFG_ROUTE_HI   11
`define MSS_CFG_ROUTE_LO   8
`define MSS_CFG_SCANCON    2
`define MSS_CFG_ABDRV      0
`define MSS_CFG_RESET      32'h0000_0000

// ----------------------------------------------------------------
// Hardscan control register fields
// ----------------------------------------------------------------
`define MSS_HARDSCAN_CONTROL_REGISTER_ENABLE    7
`define MSS_HARDSCAN_CONTROL_REGISTER_REWIND    6
`define MSS_HARDSCAN_CONTROL_REGISTER_SINGLE    4
`define MSS_HARDSCAN_CONTROL_REGISTER_KEEP      3
`define MSS_HARDSCAN_CONTROL_REGISTER_GO        0
`define MSS_HARDSCAN_CONTROL_REGISTER_RESET     8'h00

// ----------------------------------------------------------------
// Scan entry fields
// ----------------------------------------------------------------
`define MSS_ENT_SLOT_HI    10
`define MSS_ENT_SLOT_LO    7
`define MSS_ENT_CNT_HI     6
`define MSS_ENT_CNT_LO     0

// ----------------------------------------------------------------
// Register port map
// ----------------------------------------------------------------
`define MSS_ADDR_W         8
`define MSS_ADDR_STATUS    8'h00
`define MSS_ADDR_CONFIG    8'h04
`define MSS_ADDR_HARDSCAN_CONTROL_REGISTER      8'h08
`define MSS_ADDR_LEVEL     8'h0C
`define MSS_ADDR_TICK      8'h10

`endif

// [mss_pkg.sv]
// Types for the multiplexed scan sequencer
package mss_pkg;
  typedef enum logic [1:0] {
    MSS_IDLE,
    MSS_RUN,
    MSS_DONE
  } mss_state_e;
endpackage

// [mss_ser_if.sv]
// Word hand-off from a serial receiver to the core
interface mss_ser_if #(
  parameter int W = 8
);
  logic [W-1:0] word;
  logic         strobe;
  modport rx   (output word, output strobe);
  modport core (input word, input strobe);
endinterface

// [mss_ser_rx.sv]
// Serial word receiver with pin synchronisers
module mss_ser_rx
  import mss_pkg::*;
#(
  parameter int W = 8
) (
  input  wire logic clk_i,
  input  wire logic rst_i,
  input  wire logic ce_i,
  input  wire logic serial_clk_i,
  input  wire logic mosi_i,
  input  wire logic select_n_i,
  input  wire logic chassis_controller_select_n_i,
  mss_ser_if.rx     out
);

  localparam int CW = $clog2(W + 1);

  if (W < 2 || W > 64)
  begin : g_bad_w
    $error("mss_ser_rx: W out of range");
  end

  // ----------------------------------------------------------------
  // Three-stage pin synchronisers
  // ----------------------------------------------------------------
  logic [3:0] s1_reg, s2_reg, s3_reg, filt_reg, filt_next;
  logic [3:0] prev_reg;

  always_comb
  begin
    for (int i = 0; i < 4; i++)
    begin
      filt_next[i] = (s2_reg[i] == s3_reg[i]) ? s3_reg[i] : filt_reg[i];
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      s1_reg   <= 4'hF;
      s2_reg   <= 4'hF;
      s3_reg   <= 4'hF;
      filt_reg <= 4'hF;
      prev_reg <= 4'hF;
    end
    else if (ce_i)
    begin
      s1_reg   <= {serial_clk_i, mosi_i, select_n_i,
                   chassis_controller_select_n_i};
      s2_reg   <= s1_reg;
      s3_reg   <= s2_reg;
      filt_reg <= filt_next;
      prev_reg <= filt_reg;
    end
  end

  // ----------------------------------------------------------------
  // Shifter, word ends when select is released
  // ----------------------------------------------------------------
  logic         sel, sel_prev, sclk_rise;
  logic [W-1:0] sh_reg, sh_next, word_reg, word_next;
  logic [CW-1:0] cnt_reg, cnt_next;
  logic         stb_reg, stb_next;

  assign sel       = ~filt_reg[1] & ~filt_reg[0];
  assign sel_prev  = ~prev_reg[1] & ~prev_reg[0];
  assign sclk_rise = filt_reg[3] & ~prev_reg[3];

  always_comb
  begin
    sh_next   = sh_reg;
    cnt_next  = cnt_reg;
    word_next = word_reg;
    stb_next  = 1'b0;
    if (sel && !sel_prev)
    begin
      cnt_next = '0;
    end
    else if (sel && sclk_rise)
    begin
      sh_next = {sh_reg[W-2:0], filt_reg[2]};
      if (cnt_reg != CW'(W))
      begin
        cnt_next = cnt_reg + CW'(1);
      end
    end
    else if (!sel && sel_prev && cnt_reg == CW'(W))
    begin
      word_next = sh_reg;
      stb_next  = 1'b1;
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      sh_reg   <= '0;
      cnt_reg  <= '0;
      word_reg <= '0;
      stb_reg  <= 1'b0;
    end
    else if (ce_i)
    begin
      sh_reg   <= sh_next;
      cnt_reg  <= cnt_next;
      word_reg <= word_next;
      stb_reg  <= stb_next;
    end
  end

  assign out.word   = word_reg;
  assign out.strobe = stb_reg;

endmodule // mss_ser_rx

// [mss_scan_sequencer.sv]
// Multiplexed scan sequencer: config word, hardscan control and list
`include "mss_regs.svh"
module mss_scan_sequencer
  import mss_pkg::*;
#(
  parameter int DEPTH = `MSS_FIFO_DEPTH
) (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        ce_i,
  input  wire logic        serial_clk_i,
  input  wire logic        mosi_i,
  input  wire logic        module_select_n_i,
  input  wire logic        hardscan_control_register_select_n_i,
  input  wire logic        fifo_select_n_i,
  input  wire logic        chassis_controller_select_n_i,
  input  wire logic        backplane_scan_clock_line_i,
  input  wire logic [7:0]  addr_i,
  input  wire logic [31:0] wdata_i,
  input  wire logic        wr_i,
  input  wire logic        rd_i,
  output logic      [31:0] rdata_o,
  output logic             scan_running_o,
  output logic      [3:0]  active_slot_o,
  output logic      [2:0]  mux_channel_o,
  output logic             analog_bus_drive_enable_o,
  output logic             scan_connect_enable_o,
  output logic      [3:0]  hold_trigger_routing_field_o,
  output logic      [1:0]  host_board_select_field_o,
  output logic      [6:0]  sample_repeat_field_o
);

  localparam int PW = $clog2(DEPTH);

  if (DEPTH < 2 || DEPTH > 128 || (1 << PW) != DEPTH)
  begin : g_bad_depth
    $error("mss_scan_sequencer: DEPTH must be a power of two");
  end

  // ----------------------------------------------------------------
  // Serial receivers
  // ----------------------------------------------------------------
  mss_ser_if #(.W(`MSS_CFG_W))   cfg_if ();
  mss_ser_if #(.W(`MSS_HARDSCAN_CONTROL_REGISTER_W))  hardscan_control_register_if ();
  mss_ser_if #(.W(`MSS_ENTRY_W)) ent_if ();

  mss_ser_rx #(.W(`MSS_CFG_W)) u_cfg_rx (
    .clk_i                         (clk_i),
    .rst_i                         (rst_i),
    .ce_i                          (ce_i),
    .serial_clk_i                  (serial_clk_i),
    .mosi_i                        (mosi_i),
    .select_n_i                    (module_select_n_i),
    .chassis_controller_select_n_i (module_select_n_i),
    .out                           (cfg_if.rx)
  );

  mss_ser_rx #(.W(`MSS_HARDSCAN_CONTROL_REGISTER_W)) u_hardscan_control_register_rx (
    .clk_i                         (clk_i),
    .rst_i                         (rst_i),
    .ce_i                          (ce_i),
    .serial_clk_i                  (serial_clk_i),
    .mosi_i                        (mosi_i),
    .select_n_i                    (hardscan_control_register_select_n_i),
    .chassis_controller_select_n_i (chassis_controller_select_n_i),
    .out                           (hardscan_control_register_if.rx)
  );

  mss_ser_rx #(.W(`MSS_ENTRY_W)) u_ent_rx (
    .clk_i                         (clk_i),
    .rst_i                         (rst_i),
    .ce_i                          (ce_i),
    .serial_clk_i                  (serial_clk_i),
    .mosi_i                        (mosi_i),
    .select_n_i                    (fifo_select_n_i),
    .chassis_controller_select_n_i (chassis_controller_select_n_i),
    .out                           (ent_if.rx)
  );

  // ----------------------------------------------------------------
  // Entry decoding
  // ----------------------------------------------------------------
  function automatic logic [3:0] ent_slot(input logic [15:0] e);
    ent_slot = e[`MSS_ENT_SLOT_HI:`MSS_ENT_SLOT_LO] + 4'h1;
  endfunction

  function automatic logic [6:0] ent_count(input logic [15:0] e);
    ent_count = e[`MSS_ENT_CNT_HI:`MSS_ENT_CNT_LO];
  endfunction

  // ----------------------------------------------------------------
  // Scan clock synchroniser and sample tick
  // ----------------------------------------------------------------
  logic sc1_reg, sc2_reg, sc3_reg, scf_reg, scf_next, scp_reg;
  logic soft_tick, tick;

  assign scf_next  = (sc2_reg == sc3_reg) ? sc3_reg : scf_reg;
  assign soft_tick = wr_i && addr_i == `MSS_ADDR_TICK && wdata_i[0];
  assign tick      = (scp_reg & ~scf_reg) | soft_tick;

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      sc1_reg <= 1'b1;
      sc2_reg <= 1'b1;
      sc3_reg <= 1'b1;
      scf_reg <= 1'b1;
      scp_reg <= 1'b1;
    end
    else if (ce_i)
    begin
      sc1_reg <= backplane_scan_clock_line_i;
      sc2_reg <= sc1_reg;
      sc3_reg <= sc2_reg;
      scf_reg <= scf_next;
      scp_reg <= scf_reg;
    end
  end

  // ----------------------------------------------------------------
  // Configuration and hardscan control registers
  // ----------------------------------------------------------------
  logic [31:0] cfg_reg, cfg_next;
  logic [7:0]  hardscan_control_register_reg, hardscan_control_register_next;
  logic        cfg_zero;

  assign cfg_zero = cfg_if.strobe && cfg_if.word == `MSS_CFG_RESET;

  always_comb
  begin
    cfg_next  = cfg_reg;
    hardscan_control_register_next = hardscan_control_register_reg;
    if (cfg_if.strobe)
    begin
      cfg_next = cfg_if.word;
    end
    if (hardscan_control_register_if.strobe)
    begin
      hardscan_control_register_next = hardscan_control_register_if.word;
    end
  end

  // ----------------------------------------------------------------
  // Scan list storage
  // ----------------------------------------------------------------
  logic [15:0] mem [DEPTH];
  logic [PW:0] len_reg, len_next;
  logic        mem_we;

  assign mem_we = ent_if.strobe && len_reg != (PW+1)'(DEPTH);

  always_comb
  begin
    len_next = len_reg;
    if (hardscan_control_register_if.strobe && !hardscan_control_register_if.word[`MSS_HARDSCAN_CONTROL_REGISTER_KEEP])
    begin
      len_next = '0;
    end
    else if (mem_we)
    begin
      len_next = len_reg + (PW+1)'(1);
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (ce_i && mem_we)
    begin
      mem[len_reg[PW-1:0]] <= ent_if.word;
    end
  end

  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------
  mss_state_e  state_reg, state_next;
  logic [PW-1:0] idx_reg, idx_next, nidx;
  logic [6:0]  cnt_reg, cnt_next, rep_reg, rep_next, rep_cfg;
  logic [3:0]  slot_reg, slot_next;
  logic [2:0]  chan_reg, chan_next, start_ch;
  logic        last;

  assign rep_cfg  = cfg_reg[`MSS_CFG_REPEAT_HI:`MSS_CFG_REPEAT_LO];
  assign start_ch = cfg_reg[`MSS_CFG_START_HI:`MSS_CFG_START_LO];
  assign nidx     = idx_reg + PW'(1);
  assign last     = ({1'b0, idx_reg} + (PW+1)'(1)) >= len_reg;

  always_comb
  begin
    state_next = state_reg;
    idx_next   = idx_reg;
    cnt_next   = cnt_reg;
    rep_next   = rep_reg;
    slot_next  = slot_reg;
    chan_next  = chan_reg;
    case (state_reg)
      MSS_RUN:
      begin
        if (tick)
        begin
          if (rep_reg > 7'h01)
          begin
            rep_next = rep_reg - 7'h01;
          end
          else if (cnt_reg != 7'h00)
          begin
            rep_next  = rep_cfg;
            cnt_next  = cnt_reg - 7'h01;
            chan_next = chan_reg + 3'h1;
          end
          else if (last && hardscan_control_register_reg[`MSS_HARDSCAN_CONTROL_REGISTER_SINGLE])
          begin
            state_next = MSS_DONE;
          end
          else
          begin
            idx_next  = last ? '0 : nidx;
            slot_next = ent_slot(mem[last ? '0 : nidx]);
            cnt_next  = ent_count(mem[last ? '0 : nidx]);
            chan_next = start_ch;
            rep_next  = rep_cfg;
          end
        end
      end
      MSS_IDLE, MSS_DONE:
      begin
        if (hardscan_control_register_if.strobe && hardscan_control_register_if.word[`MSS_HARDSCAN_CONTROL_REGISTER_REWIND])
        begin
          idx_next = '0;
        end
        if (hardscan_control_register_if.strobe && hardscan_control_register_if.word[`MSS_HARDSCAN_CONTROL_REGISTER_ENABLE]
            && hardscan_control_register_if.word[`MSS_HARDSCAN_CONTROL_REGISTER_GO] && len_reg != '0)
        begin
          state_next = MSS_RUN;
          idx_next   = '0;
          slot_next  = ent_slot(mem[0]);
          cnt_next   = ent_count(mem[0]);
          chan_next  = start_ch;
          rep_next   = rep_cfg;
        end
      end
      default:
      begin
        state_next = MSS_IDLE;
      end
    endcase
    if (hardscan_control_register_if.strobe && !hardscan_control_register_if.word[`MSS_HARDSCAN_CONTROL_REGISTER_ENABLE])
    begin
      state_next = MSS_IDLE;
    end
    if (cfg_zero)
    begin
      chan_next = 3'h0;
      rep_next  = 7'h00;
    end
  end

  // ----------------------------------------------------------------
  // Register port
  // ----------------------------------------------------------------
  logic [31:0] rdata_next;

  always_comb
  begin
    rdata_next = 32'h0000_0000;
    if (rd_i)
    begin
      case (addr_i)
        `MSS_ADDR_STATUS:
          rdata_next = {4'h0, 8'(idx_reg), 1'b0, cnt_reg,
                        1'b0, chan_reg, slot_reg,
                        2'b00, state_reg};
        `MSS_ADDR_CONFIG: rdata_next = cfg_reg;
        `MSS_ADDR_HARDSCAN_CONTROL_REGISTER:   rdata_next = {24'h000000, hardscan_control_register_reg};
        `MSS_ADDR_LEVEL:  rdata_next = 32'(len_reg);
        default:          rdata_next = 32'h0000_0000;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // State registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      cfg_reg   <= `MSS_CFG_RESET;
      hardscan_control_register_reg  <= `MSS_HARDSCAN_CONTROL_REGISTER_RESET;
      len_reg   <= '0;
      state_reg <= MSS_IDLE;
      idx_reg   <= '0;
      cnt_reg   <= 7'h00;
      rep_reg   <= 7'h00;
      slot_reg  <= 4'h0;
      chan_reg  <= 3'h0;
      rdata_o   <= 32'h0000_0000;
    end
    else if (ce_i)
    begin
      cfg_reg   <= cfg_next;
      hardscan_control_register_reg  <= hardscan_control_register_next;
      len_reg   <= len_next;
      state_reg <= state_next;
      idx_reg   <= idx_next;
      cnt_reg   <= cnt_next;
      rep_reg   <= rep_next;
      slot_reg  <= slot_next;
      chan_reg  <= chan_next;
      rdata_o   <= rdata_next;
    end
  end

  assign scan_running_o   = state_reg == MSS_RUN;
  assign active_slot_o    = scan_running_o ? slot_reg : 4'h0;
  assign mux_channel_o    = chan_reg;
  assign analog_bus_drive_enable_o = cfg_reg[`MSS_CFG_ABDRV];
  assign scan_connect_enable_o     = cfg_reg[`MSS_CFG_SCANCON];
  assign hold_trigger_routing_field_o =
    cfg_reg[`MSS_CFG_ROUTE_HI:`MSS_CFG_ROUTE_LO];
  assign host_board_select_field_o =
    cfg_reg[`MSS_CFG_HOST_HI:`MSS_CFG_HOST_LO];
  assign sample_repeat_field_o = rep_cfg;

endmodule // mss_scan_sequencer

// [mss_host_model.sv]
// Host board model driving the serial select lines
module mss_host_model (
  output logic serial_clk_o,
  output logic mosi_o,
  output logic module_select_n_o,
  output logic hardscan_control_register_select_n_o,
  output logic fifo_select_n_o,
  output logic chassis_controller_select_n_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // ----------------------------------------------------------------
  // Idle pins and word shifting
  // ----------------------------------------------------------------
  initial
  begin
    serial_clk_o = 1'b1;
    mosi_o = 1'b0;
    {module_select_n_o, hardscan_control_register_select_n_o} = 2'h3;
    {fifo_select_n_o, chassis_controller_select_n_o} = 2'h3;
  end
  task automatic shift(input int t, input logic [31:0] w, input int n);
    module_select_n_o = (t != 0);
    hardscan_control_register_select_n_o = (t != 1);
    fifo_select_n_o = (t != 2);
    chassis_controller_select_n_o = (t == 0);
    #24;
    for (int i = n - 1; i >= 0; i--)
    begin
      serial_clk_o = 1'b0;
      mosi_o = w[i];
      #24;
      serial_clk_o = 1'b1;
      #24;
    end
    {module_select_n_o, hardscan_control_register_select_n_o} = 2'h3;
    {fifo_select_n_o, chassis_controller_select_n_o} = 2'h3;
    mosi_o = ~mosi_o;
    #60;
  endtask
  task automatic send_cfg(input logic [31:0] w);
    shift(0, w, 32);
  endtask
  task automatic send_ctl(input logic [7:0] w);
    shift(1, {24'h0, w}, 8);
  endtask
  task automatic send_ent(input logic [15:0] w);
    shift(2, {16'h0, w}, 16);
  endtask
endmodule // mss_host_model

// [mss_scan_sequencer_chk.sv]
// Port checker for the multiplexed scan sequencer
module mss_scan_sequencer_chk
  import mss_pkg::*;
#(
  parameter int DEPTH = 16
) (
  input wire logic        clk_i,
  input wire logic        rst_i,
  input wire logic        serial_clk_i,
  input wire logic        mosi_i,
  input wire logic        module_select_n_i,
  input wire logic        rd_i,
  input wire logic [31:0] rdata_o,
  input wire logic        scan_running_o,
  input wire logic [3:0]  active_slot_o,
  input wire logic [2:0]  mux_channel_o,
  input wire logic        analog_bus_drive_enable_o,
  input wire logic        scan_connect_enable_o,
  input wire logic [3:0]  hold_trigger_routing_field_o,
  input wire logic [1:0]  host_board_select_field_o,
  input wire logic [6:0]  sample_repeat_field_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // ----------------------------------------------------------------
  // Shadow of the configuration word
  // ----------------------------------------------------------------
  logic [2:0]  sck_q, sel_q, dat_q;
  logic [31:0] sh_reg, cfg_reg;
  logic [5:0]  cnt_reg;
  logic        cfg_ev;
  always_ff @(posedge clk_i)
  begin
    sck_q <= {sck_q[1:0], serial_clk_i};
    sel_q <= {sel_q[1:0], module_select_n_i};
    dat_q <= {dat_q[1:0], mosi_i};
    cfg_ev <= sel_q[2:1] == 2'h1 && cnt_reg == 6'h20;
    if (sel_q[2:1] == 2'h2)
      cnt_reg <= 6'h0;
    else if (!sel_q[2] && sck_q[2:1] == 2'h1 && cnt_reg != 6'h20)
      cnt_reg <= cnt_reg + 6'h1;
    if (!sel_q[2] && sck_q[2:1] == 2'h1)
      sh_reg <= {sh_reg[30:0], dat_q[2]};
    if (sel_q[2:1] == 2'h1 && cnt_reg == 6'h20)
      cfg_reg <= sh_reg;
    if (rst_i)
    begin
      {sck_q, sel_q} <= 6'h3F;
      cnt_reg <= 6'h0;
      cfg_reg <= 32'h0;
      cfg_ev <= 1'b0;
    end
  end
  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);
  sequence s_entry;
    scan_running_o && $past(scan_running_o) && $changed(active_slot_o);
  endsequence
  sequence s_step;
    scan_running_o && $past(scan_running_o) && $stable(active_slot_o)
      && $changed(mux_channel_o);
  endsequence
  idle_slot_a: assert property (
    !scan_running_o |-> active_slot_o == 4'h0)
    else $error("slot shown while idle");
  run_slot_a: assert property (
    scan_running_o |-> active_slot_o != 4'h0)
    else $error("no slot while running");
  start_chan_a: assert property (
    $rose(scan_running_o) |-> mux_channel_o == cfg_reg[22:20])
    else $error("scan did not start at start channel");
  entry_chan_a: assert property (
    s_entry |-> mux_channel_o == cfg_reg[22:20])
    else $error("new entry did not reload start channel");
  chan_step_a: assert property (
    s_step |-> mux_channel_o == $past(mux_channel_o) + 3'h1
      || mux_channel_o == cfg_reg[22:20])
    else $error("channel step wrong");
  cfg_load_a: assert property (cfg_ev |-> ##[1:12]
    sample_repeat_field_o == cfg_reg[30:24]
    && host_board_select_field_o == cfg_reg[13:12]
    && hold_trigger_routing_field_o == cfg_reg[11:8]
    && {scan_connect_enable_o, analog_bus_drive_enable_o}
      == {cfg_reg[2], cfg_reg[0]})
    else $error("config fields not loaded");
  zero_cfg_a: assert property (
    cfg_ev && cfg_reg == 32'h0 |-> ##[1:12]
    (mux_channel_o == 3'h0 && !analog_bus_drive_enable_o))
    else $error("zero config word did not reset");
  rd_only_a: assert property (
    rdata_o != 32'h0 |-> $past(rd_i))
    else $error("read data without read");
endmodule // mss_scan_sequencer_chk
bind mss_scan_sequencer mss_scan_sequencer_chk #(.DEPTH(DEPTH)) u_chk (
  .clk_i(clk_i), .rst_i(rst_i), .serial_clk_i(serial_clk_i),
  .mosi_i(mosi_i), .module_select_n_i(module_select_n_i), .rd_i(rd_i),
  .rdata_o(rdata_o), .scan_running_o(scan_running_o),
  .active_slot_o(active_slot_o), .mux_channel_o(mux_channel_o),
  .analog_bus_drive_enable_o(analog_bus_drive_enable_o),
  .scan_connect_enable_o(scan_connect_enable_o),
  .hold_trigger_routing_field_o(hold_trigger_routing_field_o),
  .host_board_select_field_o(host_board_select_field_o),
  .sample_repeat_field_o(sample_repeat_field_o));

// [mss_scan_sequencer_tb.sv]
// Testbench for the multiplexed scan sequencer
`include "mss_regs.svh"
`define CHK(a, e) begin cmp_count++; if ((a) !== (e)) begin errors++; \
  $display("wrong value at %0t: %h %h", $time, (a), (e)); end end
module mss_scan_sequencer_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk_i, rst_i, ce_i, scan_line, wr_i, rd_i, run, abdrv, sconn;
  logic        sck, mosi, msel_n, hsel_n, fsel_n, csel_n;
  logic [7:0]  addr_i;
  logic [31:0] wdata_i, rdata_o;
  logic [3:0]  slot, route;
  logic [2:0]  chan;
  logic [1:0]  host;
  logic [6:0]  rep;
  int          errors = 0, cmp_count = 0;
  localparam logic [6:0] WALK [6] = '{7'h26, 7'h27, 7'h20, 7'h26, 7'h27,
    7'h6E};
  localparam logic [7:0] RUN1 [4] = '{8'h2C, 8'hBC, 8'hBE, 8'hBF};
  localparam logic [7:0] REUSE [7] = '{8'h08, 8'h48, 8'h08, 8'h2C, 8'hAC,
    8'hAE, 8'hAF};
  localparam logic [3:0] ROUTE [3] = '{4'h2, 4'h0, 4'h1};
  localparam logic [1:0] HOST [3] = '{2'h2, 2'h1, 2'h1};
  mss_host_model u_mss_host_model (.serial_clk_o(sck), .mosi_o(mosi),
    .module_select_n_o(msel_n), .hardscan_control_register_select_n_o(hsel_n),
    .fifo_select_n_o(fsel_n), .chassis_controller_select_n_o(csel_n));
  mss_scan_sequencer u_mss_scan_sequencer (.clk_i(clk_i), .rst_i(rst_i),
    .ce_i(ce_i), .serial_clk_i(sck), .mosi_i(mosi),
    .module_select_n_i(msel_n), .hardscan_control_register_select_n_i(hsel_n),
    .fifo_select_n_i(fsel_n), .chassis_controller_select_n_i(csel_n),
    .backplane_scan_clock_line_i(scan_line), .addr_i(addr_i),
    .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
    .scan_running_o(run), .active_slot_o(slot), .mux_channel_o(chan),
    .analog_bus_drive_enable_o(abdrv), .scan_connect_enable_o(sconn),
    .hold_trigger_routing_field_o(route), .host_board_select_field_o(host),
    .sample_repeat_field_o(rep));
  // ----------------------------------------------------------------
  // Bus, tick and check tasks
  // ----------------------------------------------------------------
  task automatic close_out();
    if (errors == 0 && cmp_count > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    {addr_i, wdata_i, wr_i} <= {a, d, 1'b1};
    @(posedge clk_i);
    wr_i <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] v);
    @(posedge clk_i);
    {addr_i, rd_i} <= {a, 1'b1};
    @(posedge clk_i);
    rd_i <= 1'b0;
    #1;
    v = rdata_o;
  endtask
  task automatic tick(input bit sw);
    if (sw)
      wr(`MSS_ADDR_TICK, 32'h1);
    else
    begin
      @(posedge clk_i);
      scan_line <= 1'b0;
      repeat (4) @(posedge clk_i);
      scan_line <= 1'b1;
    end
    repeat (10) @(posedge clk_i);
  endtask
  task automatic walk();
    for (int i = 0; i < 6; i++)
    begin
      `CHK({run, slot, chan}, {1'b1, WALK[i]})
      tick(i[0]);
    end
  endtask
  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_cfg();
    logic [31:0] w, v;
    for (int i = 0; i < 3; i++)
    begin
      w = {8'h01, 1'b0, 3'h6, 6'h0, HOST[i], ROUTE[i], 8'h05};
      u_mss_host_model.send_cfg(w);
      `CHK({route, host, rep, abdrv, sconn}, {w[11:8], w[13:12], 9'h7})
      rd(`MSS_ADDR_CONFIG, v);
      `CHK(v, w)
    end
  endtask
  task automatic t_load();
    logic [31:0] v;
    u_mss_host_model.send_ctl(8'h00);
    rd(`MSS_ADDR_LEVEL, v);
    `CHK(v, 32'h0)
    u_mss_host_model.send_ctl(8'h08);
    u_mss_host_model.send_ent(16'h0182);
    u_mss_host_model.send_ent(16'h0181);
    u_mss_host_model.send_ent(16'h0600);
    rd(`MSS_ADDR_LEVEL, v);
    `CHK(v, 32'h3)
    foreach (RUN1[i]) u_mss_host_model.send_ctl(RUN1[i]);
    walk();
    `CHK({run, slot}, 5'h0)
    rd(`MSS_ADDR_STATUS, v);
    `CHK(v[1:0], 2'h2)
  endtask
  task automatic t_reuse();
    logic [31:0] v;
    foreach (REUSE[i]) u_mss_host_model.send_ctl(REUSE[i]);
    walk();
    `CHK({run, slot, chan}, 8'hA6)
    tick(1'b0);
    `CHK({run, slot, chan}, 8'hA7)
    @(posedge clk_i);
    ce_i <= 1'b0;
    tick(1'b1);
    tick(1'b0);
    ce_i <= 1'b1;
    repeat (4) @(posedge clk_i);
    `CHK({run, slot, chan}, 8'hA7)
    u_mss_host_model.send_ctl(8'h08);
    `CHK(run, 1'b0)
    rd(`MSS_ADDR_HARDSCAN_CONTROL_REGISTER, v);
    `CHK(v, 32'h08)
  endtask
  task automatic t_zero();
    logic [31:0] v;
    u_mss_host_model.send_cfg(32'h0);
    `CHK({abdrv, chan, sconn, route, host, rep}, 18'h0)
    rd(`MSS_ADDR_CONFIG, v);
    `CHK(v, 32'h0)
    rd(8'h20, v);
    `CHK(v, 32'h0)
  endtask
  initial
  begin
    clk_i = 1'b0;
    forever #2 clk_i = ~clk_i;
  end
  initial
  begin
    #200000;
    errors++;
    close_out();
  end
  initial
  begin
    {rst_i, ce_i, scan_line, wr_i, rd_i} = 5'h1C;
    {addr_i, wdata_i} = 40'h0;
    repeat (20) @(posedge clk_i);
    rst_i <= 1'b0;
    repeat (8) @(posedge clk_i);
    t_cfg();
    t_load();
    t_reuse();
    t_zero();
    close_out();
  end
endmodule // mss_scan_sequencer_tb
